// *** teletext_window_sync_timing.sv ***
// Teletext request, line window and sync timing configuration bank
// Notes on behaviour
// - edge bits 6..4 are end MSBs
// - edge bits 2..0 are start MSBs
// - request starts at programmed horizontal position
// - sample data programmed cycles after request rise
// - composite sync advanced 0 to 31 clocks
// - master mode delays vertical sync on timing output a by the 0 to 7 clock shift code
// - odd first line is code plus offset
// - odd last line is code plus offset
// - even first line is code plus offset
// - even last line is code plus offset
// - first active line is code plus offset
// - nine-bit codes join low and shared MSB
// - one teletext bit per request rising edge
`include "teletext_timing_map.svh"
module teletext_window_sync_timing #(
  parameter logic [8:0] BURST_BITS = 9'h168
) (
  input  wire logic                           clk,
  input  wire logic                           sys_rst,
  input  wire logic [7:0]                     reg_addr,
  input  wire logic [7:0]                     reg_wdata,
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  output logic [7:0]                          reg_rdata,
  input  teletext_timing_pkg::raster_pos_type raster,
  input  wire logic                           field_rate_select,
  input  wire logic                           master_mode,
  input  wire logic                           rgb_sync_in,
  input  wire logic                           csync_in,
  input  wire logic                           vsync_in,
  input  wire logic                           teletext_data_in,
  output logic                                teletext_request_out,
  output logic                                teletext_bit,
  output logic                                teletext_bit_valid,
  output logic                                rgb_sync_out,
  output logic                                composite_sync_out,
  output logic                                timing_out_a,
  output logic                                timing_out_b,
  output logic [9:0]                          first_active_line
);
  import teletext_timing_pkg::*;

  localparam int NREGS = 9;
  localparam logic [7:0] RST_VALS [NREGS] = '{
    `RST_EDGE_MSBS, `RST_REQ_START, `RST_DATA_DELAY, `RST_ADV_SHIFT, `RST_ODD_FIRST,
    `RST_ODD_LAST, `RST_EVEN_FIRST, `RST_EVEN_LAST, `RST_ACTIVE_LOW};

  // Register bank
  logic [7:0] regs_q [NREGS];
  logic [7:0] regs_d [NREGS];
  logic [7:0] msbs_q;
  logic [7:0] msbs_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [7:0] idx;
  logic       in_bank;

  always_comb begin
    idx     = reg_addr - `ADDR_EDGE_MSBS;
    in_bank = (reg_addr >= `ADDR_EDGE_MSBS) && (reg_addr <= `ADDR_ACTIVE_LOW);
    for (int i = 0; i < NREGS; i++) begin
      regs_d[i] = regs_q[i];
    end
    msbs_d = msbs_q;
    if (reg_wr && in_bank) begin
      regs_d[idx[3:0]] = reg_wdata;
      if (reg_addr == `ADDR_EDGE_MSBS) begin
        regs_d[0] = reg_wdata & `EDGE_WRITE_MASK;
      end
    end
    if (reg_wr && reg_addr == `ADDR_LINE_MSBS) begin
      msbs_d = reg_wdata & `LINE_MSBS_MASK;
    end
    rdata_d = rdata_q;
    if (reg_rd) begin
      if (in_bank) begin
        rdata_d = regs_q[idx[3:0]];
      end else if (reg_addr == `ADDR_LINE_MSBS) begin
        rdata_d = msbs_q;
      end else begin
        rdata_d = 8'h00;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < NREGS; i++) begin
        regs_q[i] <= RST_VALS[i];
      end
      msbs_q  <= `RST_LINE_MSBS;
      rdata_q <= 8'h00;
    end else begin
      for (int i = 0; i < NREGS; i++) begin
        regs_q[i] <= regs_d[i];
      end
      msbs_q  <= msbs_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // Combined codes
  timing_b_codes_type b_codes;
  line_window_type    windows [2];
  logic [7:0]         req_start;
  logic [7:0]         data_delay;
  logic [4:0]         adv;
  logic [2:0]         vs_shift;
  logic [8:0]         act_code;

  always_comb begin
    b_codes.stop  = {regs_q[0][`EDGE_END_MSB:`EDGE_END_LSB], 8'h00};
    b_codes.start = {regs_q[0][`EDGE_START_MSB:`EDGE_START_LSB], 8'h00};
    req_start     = regs_q[1];
    data_delay    = regs_q[2];
    adv           = regs_q[3][`ADV_MSB:`ADV_LSB];
    vs_shift      = regs_q[3][`VS_SHIFT_MSB:`VS_SHIFT_LSB];
    windows[0]    = '{first: {msbs_q[`MSB_ODD_FIRST], regs_q[4]},
                      last:  {msbs_q[`MSB_ODD_LAST], regs_q[5]}};
    windows[1]    = '{first: {msbs_q[`MSB_EVEN_FIRST], regs_q[6]},
                      last:  {msbs_q[`MSB_EVEN_LAST], regs_q[7]}};
    act_code      = {msbs_q[`MSB_ACTIVE], regs_q[8]};
  end

  // Low bytes of the edge codes sit in neighbouring registers outside this bank
  logic [7:0] b_start_low;
  logic [7:0] b_end_low;
  assign b_start_low = 8'h00;
  assign b_end_low   = 8'h00;

  timing_b_codes_type b_full;
  always_comb begin
    b_full.start = b_codes.start | {3'h0, b_start_low};
    b_full.stop  = b_codes.stop | {3'h0, b_end_low};
  end

  // Field windows, odd is entry 0
  logic [1:0] in_win;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_win
      line_window_check u_win (
        .codes      (windows[g]),
        .m_system   (field_rate_select),
        .line       (raster.line),
        .first_line (),
        .last_line  (),
        .in_window  (in_win[g])
      );
    end
  endgenerate

  logic win_active;
  assign win_active = raster.odd_field ? in_win[0] : in_win[1];

  // First active line
  logic [9:0] act_d;
  logic [9:0] act_q;
  always_comb begin
    act_d = {1'b0, act_code} + (field_rate_select ? `FIRST_OFS_M : `FIRST_OFS_OTHER);
  end

  // Request generator: one short high pulse per bit so every bit has its own rising edge
  req_state_type state_q;
  req_state_type state_d;
  logic [8:0]    cnt_q;
  logic [8:0]    cnt_d;
  logic          done_q;
  logic          done_d;
  logic          req_q;
  logic          req_d;
  logic          rise_q;
  logic          rise_d;
  logic          start_hit;

  always_comb begin
    start_hit = (raster.pixel == {3'h0, req_start});
    state_d   = state_q;
    cnt_d     = cnt_q;
    done_d    = done_q;
    if (raster.pixel == 11'h000) begin
      done_d = 1'b0;
    end
    case (state_q)
      REQ_IDLE: begin
        if (start_hit && win_active && !done_q) begin
          state_d = REQ_HIGH;
          cnt_d   = 9'h001;
        end
      end
      REQ_HIGH: begin
        state_d = REQ_LOW;
      end
      REQ_LOW: begin
        if (cnt_q >= BURST_BITS || !win_active) begin
          state_d = REQ_IDLE;
          done_d  = 1'b1;
        end else begin
          state_d = REQ_HIGH;
          cnt_d   = cnt_q + 9'h001;
        end
      end
      default: begin
        state_d = REQ_IDLE;
      end
    endcase
    req_d  = (state_d == REQ_HIGH);
    rise_d = req_d && !req_q;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= REQ_IDLE;
      cnt_q   <= 9'h000;
      done_q  <= 1'b0;
      req_q   <= 1'b0;
      rise_q  <= 1'b0;
      act_q   <= 10'h000;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      done_q  <= done_d;
      req_q   <= req_d;
      rise_q  <= rise_d;
      act_q   <= act_d;
    end
  end

  assign teletext_request_out = req_q;
  assign first_active_line    = act_q;

  // Bit sampling, the rise pulse lines up with the request edge
  teletext_sampler u_sampler (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .req_rise   (rise_q),
    .data_delay (data_delay),
    .data_pin   (teletext_data_in),
    .bit_q      (teletext_bit),
    .valid_q    (teletext_bit_valid)
  );

  // Sync delay lines: RGB gets the full depth so composite sync can run ahead of it
  logic [`CSYNC_DEPTH-1:0] rgb_pipe_q;
  logic [`CSYNC_DEPTH-1:0] rgb_pipe_d;
  logic [`CSYNC_DEPTH-1:0] cs_pipe_q;
  logic [`CSYNC_DEPTH-1:0] cs_pipe_d;
  logic [`VS_DEPTH-1:0]    vs_pipe_q;
  logic [`VS_DEPTH-1:0]    vs_pipe_d;
  logic                    tob_q;
  logic                    tob_d;
  logic [4:0]              cs_tap;

  always_comb begin
    rgb_pipe_d = {rgb_pipe_q[`CSYNC_DEPTH-2:0], rgb_sync_in};
    cs_pipe_d  = {cs_pipe_q[`CSYNC_DEPTH-2:0], csync_in};
    vs_pipe_d  = {vs_pipe_q[`VS_DEPTH-2:0], vsync_in};
    cs_tap     = `CSYNC_MAX_TAP - adv;
    if (b_full.start <= b_full.stop) begin
      tob_d = (raster.pixel >= b_full.start) && (raster.pixel < b_full.stop);
    end else begin
      tob_d = (raster.pixel >= b_full.start) || (raster.pixel < b_full.stop);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rgb_pipe_q <= '0;
      cs_pipe_q  <= '0;
      vs_pipe_q  <= '0;
      tob_q      <= 1'b0;
    end else begin
      rgb_pipe_q <= rgb_pipe_d;
      cs_pipe_q  <= cs_pipe_d;
      vs_pipe_q  <= vs_pipe_d;
      tob_q      <= tob_d;
    end
  end

  assign rgb_sync_out       = rgb_pipe_q[`CSYNC_DEPTH-1];
  assign composite_sync_out = cs_pipe_q[cs_tap];
  assign timing_out_a       = master_mode ? vs_pipe_q[vs_shift] : vs_pipe_q[0];
  assign timing_out_b       = tob_q;

  // Checks
  logic [5:0] warm_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      warm_q <= 6'h00;
    end else if (warm_q != `WARM_CYCLES) begin
      warm_q <= warm_q + 6'h01;
    end
  end
  logic warm;
  assign warm = (warm_q == `WARM_CYCLES);

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  reserved_bits_a: assert property (
    reg_rd && reg_addr == `ADDR_EDGE_MSBS
    |=> reg_rdata[`EDGE_RSVD_HI] == 1'b0 && reg_rdata[`EDGE_RSVD_LO] == 1'b0)
    else $error("reserved edge bits read back nonzero");
  edge_end_a: assert property (
    reg_wr && reg_addr == `ADDR_EDGE_MSBS |=> b_full.stop[10:8] == $past(reg_wdata[6:4]))
    else $error("end code MSBs not taken from write");
  edge_start_a: assert property (
    reg_wr && reg_addr == `ADDR_EDGE_MSBS |=> b_full.start[10:8] == $past(reg_wdata[2:0]))
    else $error("start code MSBs not taken from write");
  req_start_a: assert property (
    $rose(teletext_request_out) && $past(state_q == REQ_IDLE)
    |-> $past(raster.pixel) == {3'h0, $past(req_start)})
    else $error("request burst began at wrong position");
  csync_zero_a: assert property (
    warm && adv == 5'h00 |-> composite_sync_out == $past(csync_in, 32))
    else $error("composite sync moved with zero advance");
  csync_max_a: assert property (
    warm && adv == 5'h1F |-> composite_sync_out == $past(csync_in))
    else $error("composite sync not fully advanced");
  vs_shift_a: assert property (
    warm && master_mode && vs_shift == 3'h3 |-> timing_out_a == $past(vsync_in, 4))
    else $error("vertical sync shift of three not applied");
  active_line_a: assert property (
    reg_wr && reg_addr == `ADDR_ACTIVE_LOW && !field_rate_select && $stable(msbs_q)
    ##1 $stable(field_rate_select)
    |=> first_active_line == {1'b0, msbs_q[`MSB_ACTIVE], $past(reg_wdata, 2)} + 10'h001)
    else $error("first active line not code plus one");
  req_window_a: assert property (
    $rose(teletext_request_out) |-> $past(win_active))
    else $error("request outside field window");
  req_pulse_a: assert property (
    teletext_request_out |=> !teletext_request_out && cnt_q <= BURST_BITS)
    else $error("request pulse longer than one cycle");
  tob_edge_a: assert property (
    b_full.start < b_full.stop && raster.pixel == b_full.start |=> timing_out_b)
    else $error("timing output b not raised at start code");

endmodule // teletext_window_sync_timing

// *** teletext_timing_map.svh ***
// Subaddresses, field positions, reset values and timing counts of the teletext timing bank
`ifndef TELETEXT_TIMING_MAP_SVH
`define TELETEXT_TIMING_MAP_SVH

`define ADDR_EDGE_MSBS      8'h72
`define ADDR_REQ_START      8'h73
`define ADDR_DATA_DELAY     8'h74
`define ADDR_ADV_SHIFT      8'h75
`define ADDR_ODD_FIRST      8'h76
`define ADDR_ODD_LAST       8'h77
`define ADDR_EVEN_FIRST     8'h78
`define ADDR_EVEN_LAST      8'h79
`define ADDR_ACTIVE_LOW     8'h7A
`define ADDR_LINE_MSBS      8'h7C

`define EDGE_RSVD_HI        7
`define EDGE_END_MSB        6
`define EDGE_END_LSB        4
`define EDGE_RSVD_LO        3
`define EDGE_START_MSB      2
`define EDGE_START_LSB      0
`define EDGE_WRITE_MASK     8'h77

`define ADV_MSB             7
`define ADV_LSB             3
`define VS_SHIFT_MSB        2
`define VS_SHIFT_LSB        0

`define MSB_ODD_FIRST       0
`define MSB_EVEN_FIRST      1
`define MSB_ODD_LAST        2
`define MSB_EVEN_LAST       3
`define MSB_ACTIVE          4
`define LINE_MSBS_MASK      8'h1F

`define RST_EDGE_MSBS       8'h00
`define RST_REQ_START       8'h42
`define RST_DATA_DELAY      8'h02
`define RST_ADV_SHIFT       8'h03
`define RST_ODD_FIRST       8'h05
`define RST_ODD_LAST        8'h16
`define RST_EVEN_FIRST      8'h04
`define RST_EVEN_LAST       8'h16
`define RST_ACTIVE_LOW      8'h00
`define RST_LINE_MSBS       8'h00

`define FIRST_OFS_M         10'h004
`define FIRST_OFS_OTHER     10'h001
`define LAST_OFS_M          10'h003
`define LAST_OFS_OTHER      10'h000

`define DATA_DELAY_MIN      8'h02
`define CSYNC_DEPTH         32
`define CSYNC_MAX_TAP       5'h1F
`define VS_DEPTH            8
`define SAMPLE_DEPTH        257
`define WARM_CYCLES         6'h28

`endif

// *** teletext_timing_pkg.sv ***
// Types shared by the teletext window and sync timing bank
package teletext_timing_pkg;

  typedef struct packed {
    logic [10:0] start;
    logic [10:0] stop;
  } timing_b_codes_type;

  typedef struct packed {
    logic [8:0] first;
    logic [8:0] last;
  } line_window_type;

  typedef struct packed {
    logic [9:0]  line;
    logic [10:0] pixel;
    logic        odd_field;
  } raster_pos_type;

  typedef enum logic [1:0] {
    REQ_IDLE = 2'b00,
    REQ_HIGH = 2'b01,
    REQ_LOW  = 2'b10
  } req_state_type;

endpackage

// *** line_window_check.sv ***
// Line window decode of one field: first and last teletext line and membership test
`include "teletext_timing_map.svh"
module line_window_check (
  input  teletext_timing_pkg::line_window_type codes,
  input  wire logic                            m_system,
  input  wire logic [9:0]                      line,
  output logic [9:0]                           first_line,
  output logic [9:0]                           last_line,
  output logic                                 in_window
);
  import teletext_timing_pkg::*;

  always_comb begin
    first_line = {1'b0, codes.first} + (m_system ? `FIRST_OFS_M : `FIRST_OFS_OTHER);
    last_line  = {1'b0, codes.last} + (m_system ? `LAST_OFS_M : `LAST_OFS_OTHER);
    in_window  = (line >= first_line) && (line <= last_line);
  end

endmodule // line_window_check

// *** teletext_sampler.sv ***
// Teletext data pin synchroniser and delayed sampling of one bit per request edge
`include "teletext_timing_map.svh"
module teletext_sampler (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       req_rise,
  input  wire logic [7:0] data_delay,
  input  wire logic       data_pin,
  output logic            bit_q,
  output logic            valid_q
);
  import teletext_timing_pkg::*;

  logic [`SAMPLE_DEPTH-1:0] edge_pipe_q;
  logic [`SAMPLE_DEPTH-1:0] edge_pipe_d;
  logic                     sync1_q;
  logic                     sync2_q;
  logic                     bit_d;
  logic                     valid_d;
  logic [8:0]               tap;

  // Edge pipe lets several requests be in flight when the delay exceeds the request period
  always_comb begin
    edge_pipe_d = {edge_pipe_q[`SAMPLE_DEPTH-2:0], req_rise};
    tap         = {1'b0, data_delay} + 9'h001;
    valid_d     = edge_pipe_q[tap];
    bit_d       = valid_d ? sync2_q : bit_q;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      edge_pipe_q <= '0;
      sync1_q     <= 1'b0;
      sync2_q     <= 1'b0;
      bit_q       <= 1'b0;
      valid_q     <= 1'b0;
    end else begin
      edge_pipe_q <= edge_pipe_d;
      sync1_q     <= data_pin;
      sync2_q     <= sync1_q;
      bit_q       <= bit_d;
      valid_q     <= valid_d;
    end
  end

endmodule // teletext_sampler

// *** teletext_source_model.sv ***
// Teletext data source model: one bit per request edge, after the programmed delay
module teletext_source_model (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       req,
  input  wire logic [7:0] delay,
  output logic            data_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int   cyc = 0;
  int   hold = 0;
  int   due_q[$];
  logic sent_q[$];
  logic req_prev = 1'b0;
  logic nb;
  initial data_pin = 1'b0;
  // Released pin shows the inverse, so a stale sample cannot pass by luck
  always @(posedge clk) begin
    cyc <= cyc + 1;
    req_prev <= req;
    if (sys_rst) begin
      due_q.delete();
      sent_q.delete();
    end else if (req && !req_prev) begin
      due_q.push_back(cyc + int'(delay) - 1);
    end
    if (due_q.size() > 0 && due_q[0] == cyc) begin
      nb = 1'($urandom);
      void'(due_q.pop_front());
      sent_q.push_back(nb);
      data_pin <= nb;
      hold <= 2;
    end else if (hold > 0) begin
      hold <= hold - 1;
      if (hold == 1) data_pin <= ~data_pin;
    end
  end
endmodule  // teletext_source_model

// *** teletext_window_sync_timing_tb_top.sv ***
// Self-checking bench of the teletext window and sync timing bank
module teletext_window_sync_timing_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import teletext_timing_pkg::*;
  // Short bursts keep the run brief; the run_line pixel loop length and expected pulse counts derive from it
  localparam logic [8:0] BITS = 9'h010;
  localparam logic [7:0] ADR [10] = '{8'h72, 8'h73, 8'h74, 8'h75, 8'h76, 8'h77, 8'h78, 8'h79,
                                      8'h7A, 8'h7C};
  localparam logic [7:0] RSTV [10] = '{8'h00, 8'h42, 8'h02, 8'h03, 8'h05, 8'h16, 8'h04, 8'h16,
                                       8'h00, 8'h00};
  localparam logic [7:0] MSK [10] = '{8'h77, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
                                      8'hFF, 8'h1F};
  logic           clk = 1'b0;
  logic           sys_rst = 1'b1;
  logic [7:0]     reg_addr = 8'h00;
  logic [7:0]     reg_wdata = 8'h00;
  logic           reg_wr = 1'b0;
  logic           reg_rd = 1'b0;
  logic [7:0]     reg_rdata;
  raster_pos_type raster = '0;
  logic           field_rate_select = 1'b0;
  logic           master_mode = 1'b0;
  logic           rgb_sync_in = 1'b0;
  logic           csync_in = 1'b0;
  logic           vsync_in = 1'b0;
  logic           teletext_data_in;
  logic           teletext_request_out;
  logic           teletext_bit;
  logic           teletext_bit_valid;
  logic           rgb_sync_out;
  logic           composite_sync_out;
  logic           timing_out_a;
  logic           timing_out_b;
  logic [9:0]     first_active_line;
  logic [7:0]     dly = 8'h02;
  logic [7:0]     d;
  logic           sync_on = 1'b0;
  logic           exp_bit;
  logic           rh[$];
  logic           ch[$];
  logic           vh[$];
  int             adv = 0;
  int             shift = 0;
  int             errors = 0;
  int             total_checks = 0;

  teletext_window_sync_timing #(.BURST_BITS(BITS)) teletext_window_sync_timing_inst (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .raster(raster),
    .field_rate_select(field_rate_select), .master_mode(master_mode),
    .rgb_sync_in(rgb_sync_in), .csync_in(csync_in), .vsync_in(vsync_in),
    .teletext_data_in(teletext_data_in), .teletext_request_out(teletext_request_out),
    .teletext_bit(teletext_bit), .teletext_bit_valid(teletext_bit_valid),
    .rgb_sync_out(rgb_sync_out),
    .composite_sync_out(composite_sync_out), .timing_out_a(timing_out_a),
    .timing_out_b(timing_out_b), .first_active_line(first_active_line));

  teletext_source_model teletext_source_model_inst (
    .clk(clk), .sys_rst(sys_rst), .req(teletext_request_out), .delay(dly),
    .data_pin(teletext_data_in));

  always #12.5 clk = ~clk;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask

  task automatic do_reset();
    sys_rst = 1'b1;
    dly = 8'h02;
    repeat (16) @(negedge clk);
    sys_rst = 1'b0;
  endtask

  // One line of raster; counts request pulses and checks the first one
  task automatic run_line(input int ln, input int odd, input int st, input bit inw);
    int n;
    int nv;
    n = 0;
    nv = 0;
    raster.line = 10'(ln);
    raster.odd_field = odd[0];
    for (int p = 0; p < st + 2 * BITS + 16; p++) begin
      raster.pixel = 11'(p);
      @(negedge clk);
      if (p == st) chk(16'(teletext_request_out), 16'(inw));
      if (teletext_request_out === 1'b1) n++;
      if (teletext_bit_valid === 1'b1) nv++;
    end
    chk(16'(n), inw ? 16'(BITS) : 16'h0000);
    chk(16'(nv), inw ? 16'(BITS) : 16'h0000);
  endtask

  // Random sync levels; delay model kept as histories, newest first
  always @(negedge clk) begin
    if (sync_on) begin
      chk(16'(rgb_sync_out), 16'(rh[31]));
      chk(16'(composite_sync_out), 16'(ch[31 - adv]));
      chk(16'(timing_out_a), 16'(vh[master_mode ? shift : 0]));
    end
    if (teletext_bit_valid === 1'b1) begin
      exp_bit = 1'bx;
      if (teletext_source_model_inst.sent_q.size() > 0)
        exp_bit = teletext_source_model_inst.sent_q.pop_front();
      chk(16'(teletext_bit), 16'(exp_bit));
    end
    rgb_sync_in = 1'($urandom);
    csync_in = 1'($urandom);
    vsync_in = 1'($urandom);
    rh.push_front(rgb_sync_in);
    ch.push_front(csync_in);
    vh.push_front(vsync_in);
    if (rh.size() > 40) begin
      void'(rh.pop_back());
      void'(ch.pop_back());
      void'(vh.pop_back());
    end
  end

  initial begin
    #1000000;
    errors++;
    wrap_up();
  end

  initial begin
    int s, e, fl, ll, st, ln;
    logic [8:0] c, fo, lo, fe, le;
    logic [7:0] v;
    void'($urandom(81));
    do_reset();
    for (int i = 0; i < 10; i++) begin
      v = 8'($urandom);
      if (i == 0) v = v & 8'h77;
      wr(ADR[i], v);
      rd(ADR[i]);
      chk(16'(d), 16'(v & MSK[i]));
    end
    wr(8'h7B, 8'hA5);
    rd(8'h7B);
    chk(16'(d), 16'h0000);
    do_reset();
    for (int i = 0; i < 10; i++) begin
      rd(ADR[i]);
      chk(16'(d), 16'(RSTV[i]));
    end
    // Edge codes kept at or below 600H, inside both line lengths
    for (int k = 0; k < 4; k++) begin
      s = (k == 0) ? 1 : (k == 1) ? 5 : $urandom_range(6, 0);
      e = (k == 0) ? 4 : (k == 1) ? 2 : $urandom_range(6, 0);
      wr(8'h72, {1'b0, 3'(e), 1'b0, 3'(s)});
      for (int p = 0; p < 2048; p++) begin
        raster.pixel = 11'(p);
        @(negedge clk);
        chk(16'(timing_out_b), 16'((s <= e) ? (p >= s * 256 && p < e * 256)
                                              : (p >= s * 256 || p < e * 256)));
      end
    end
    for (int k = 0; k < 4; k++) begin
      c = 9'($urandom);
      field_rate_select = k[0];
      wr(8'h7A, c[7:0]);
      wr(8'h7C, {3'h0, c[8], 4'h0});
      repeat (2) @(negedge clk);
      chk(16'(first_active_line), 16'(c) + (k[0] ? 16'h0004 : 16'h0001));
    end
    for (int k = 0; k < 4; k++) begin
      // Park pixel off every start value so no burst fires while registers change
      raster.pixel = 11'h7FF;
      field_rate_select = k[1];
      dly = 8'($urandom_range(9, 2));
      st = $urandom_range(200, 1);
      c = 9'($urandom_range(500, 0));
      fo = k[0] ? c : c + 9'h028;
      lo = fo + 9'($urandom_range(3, 0));
      fe = k[0] ? c + 9'h028 : c;
      le = fe + 9'($urandom_range(3, 0));
      wr(8'h73, 8'(st));
      wr(8'h74, dly);
      wr(8'h76, fo[7:0]);
      wr(8'h77, lo[7:0]);
      wr(8'h78, fe[7:0]);
      wr(8'h79, le[7:0]);
      wr(8'h7C, {4'h0, le[8], lo[8], fe[8], fo[8]});
      fl = int'(k[0] ? fo : fe) + (k[1] ? 4 : 1);
      ll = int'(k[0] ? lo : le) + (k[1] ? 3 : 0);
      for (int j = 0; j < 4; j++) begin
        ln = (j < 2) ? fl - 1 + j : ll + j - 2;
        run_line(ln, k[0], st, ln >= fl && ln <= ll);
      end
    end
    for (int k = 0; k < 6; k++) begin
      adv = (k == 0) ? 0 : (k == 1) ? 31 : $urandom_range(31, 0);
      shift = (k == 1) ? 3 : $urandom_range(7, 0);
      sync_on = 1'b0;
      master_mode = k[0];
      wr(8'h75, {5'(adv), 3'(shift)});
      repeat (40) @(negedge clk);
      sync_on = 1'b1;
      repeat (30) @(negedge clk);
    end
    sync_on = 1'b0;
    wrap_up();
  end
endmodule  // teletext_window_sync_timing_tb_top
